// ### crc_config.sv
/*
  programmable crc unit: ahb-lite register slave, polynomial and width
  configuration, input queue, serial shifter and interrupt.
  assumes a single ahb-lite master whose hready is this slave's hreadyout.
*/

module crc_config (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output      logic        hreadyout,
  output      logic        hresp,
  output      logic [31:0] hrdata,
  output      logic        irq
);
  typedef struct packed {
    logic [15:0] ctrl_one;
    logic [15:0] mask_low;
    logic [15:0] mask_high;
    logic        shift_order_select;
    logic        shifter_run;
    logic        irq_source_select;
    logic [1:0]  irq_status;
    logic [1:0]  irq_mask;
    logic        empty_q;
    logic [7:0]  addr;
    logic        pend_write;
    logic        pend_read;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        irq;
  } regs_s;

  regs_s             st;
  regs_s             next_st;
  crc_pkg::crc_cfg_s cfg;
  logic [31:0]       rd_value;
  logic              push;
  logic              preload;
  logic              clear_status;
  logic              crc_event;
  logic              ovf_event;
  logic              addr_phase;
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic [31:0]       fifo_out_data;
  logic              fifo_empty;
  logic              word_pop;
  logic [31:0]       crc_result_word;
  logic              shift_busy;
  logic              shift_done;

  assign addr_phase = hsel && hready && htrans[1];

  assign cfg.word_width_minus_one  = st.ctrl_one[crc_pkg::WW_MSB:crc_pkg::WW_LSB];
  assign cfg.poly_length_minus_one = st.ctrl_one[crc_pkg::PL_MSB:crc_pkg::PL_LSB];
  assign cfg.poly_mask             = {st.mask_high, st.mask_low[15:1], 1'b0};
  assign cfg.shift_order_select    = st.shift_order_select;

  // writes to a full queue are dropped and flagged, the write never stalls the bus
  word_queue #(
    .WIDTH (crc_pkg::WORD_W),
    .DEPTH (crc_pkg::FIFO_DEPTH)
  ) u_queue (
    .clk       (hclk),
    .rst_n     (hresetn),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (hwdata),
    .out_valid (fifo_out_valid),
    .out_ready (word_pop),
    .out_data  (fifo_out_data),
    .empty     (fifo_empty)
  );

  crc_shifter u_shifter (
    .clk           (hclk),
    .rst_n         (hresetn),
    .cfg           (cfg),
    .run           (st.shifter_run),
    .word_valid    (fifo_out_valid),
    .word          (fifo_out_data),
    .word_pop      (word_pop),
    .preload       (preload),
    .preload_value (hwdata),
    .crc           (crc_result_word),
    .busy          (shift_busy),
    .done          (shift_done)
  );

  always_comb begin
    next_st      = st;
    rd_value     = 32'h0000_0000;
    push         = 1'b0;
    preload      = 1'b0;
    clear_status = 1'b0;
    ovf_event    = 1'b0;
    next_st.empty_q = fifo_empty;
    crc_event = st.irq_source_select ? (fifo_empty && !st.empty_q) : shift_done;
    // write data phase: hwdata stands in this cycle
    if (st.pend_write) begin
      next_st.pend_write = 1'b0;
      case (st.addr)
        crc_pkg::OFS_CTRL_ONE: begin
          next_st.ctrl_one = hwdata[15:0] & crc_pkg::CTRL_ONE_MASK;
        end
        crc_pkg::OFS_MASK_LOW: begin
          next_st.mask_low = hwdata[15:0] & crc_pkg::MASK_LOW_MASK;
        end
        crc_pkg::OFS_MASK_HIGH: begin
          next_st.mask_high = hwdata[15:0] & crc_pkg::MASK_HIGH_MASK;
        end
        crc_pkg::OFS_CTRL_TWO: begin
          next_st.shift_order_select = hwdata[crc_pkg::ORDER_BIT];
          next_st.shifter_run        = hwdata[crc_pkg::RUN_BIT];
          next_st.irq_source_select  = hwdata[crc_pkg::ISEL_BIT];
        end
        crc_pkg::OFS_DATA_IN: begin
          push      = 1'b1;
          ovf_event = !fifo_in_ready;
        end
        crc_pkg::OFS_RESULT: begin
          preload = 1'b1;
        end
        crc_pkg::OFS_IRQ_MASK: begin
          next_st.irq_mask = hwdata[1:0];
        end
        default: begin
        end
      endcase
    end
    // read takes one wait state so a preceding write is always visible
    if (st.pend_read) begin
      case (st.addr)
        crc_pkg::OFS_CTRL_ONE: begin
          rd_value[15:0] = st.ctrl_one;
        end
        crc_pkg::OFS_MASK_LOW: begin
          rd_value[15:0] = st.mask_low;
        end
        crc_pkg::OFS_MASK_HIGH: begin
          rd_value[15:0] = st.mask_high;
        end
        crc_pkg::OFS_CTRL_TWO: begin
          rd_value[crc_pkg::FULL_BIT]  = !fifo_in_ready;
          rd_value[crc_pkg::EMPTY_BIT] = fifo_empty;
          rd_value[crc_pkg::RUN_BIT]   = st.shifter_run;
          rd_value[crc_pkg::ORDER_BIT] = st.shift_order_select;
          rd_value[crc_pkg::ISEL_BIT]  = st.irq_source_select;
        end
        crc_pkg::OFS_RESULT: begin
          rd_value = crc_result_word;
        end
        crc_pkg::OFS_IRQ_STATUS: begin
          rd_value[1:0] = st.irq_status;
          clear_status  = 1'b1;
        end
        crc_pkg::OFS_IRQ_MASK: begin
          rd_value[1:0] = st.irq_mask;
        end
        default: begin
        end
      endcase
      next_st.hrdata    = rd_value;
      next_st.hreadyout = 1'b1;
      next_st.pend_read = 1'b0;
    end
    if (addr_phase) begin
      next_st.addr = haddr[crc_pkg::ADDR_W-1:0];
      if (hwrite) begin
        next_st.pend_write = 1'b1;
      end else begin
        next_st.pend_read = 1'b1;
        next_st.hreadyout = 1'b0;
      end
    end
    // an event in the clearing cycle survives the read
    next_st.irq_status = (clear_status ? crc_pkg::IRQ_RESET : st.irq_status) |
                         {ovf_event, crc_event};
    next_st.irq        = |(next_st.irq_status & next_st.irq_mask);
    next_st.hresp      = 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st           <= '0;
      st.ctrl_one  <= crc_pkg::REG_RESET;
      st.mask_low  <= crc_pkg::REG_RESET;
      st.mask_high <= crc_pkg::REG_RESET;
      st.hreadyout <= 1'b1;
      st.empty_q   <= 1'b1; // idle queue is empty, so no false edge at release
    end else begin
      st <= next_st;
    end
  end

  assign hreadyout = st.hreadyout;
  assign hresp     = st.hresp;
  assign hrdata    = st.hrdata;
  assign irq       = st.irq;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_wr(logic [7:0] ofs);
    addr_phase && hwrite && (haddr[7:0] == ofs);
  endsequence

  sequence s_rd(logic [7:0] ofs);
    addr_phase && !hwrite && (haddr[7:0] == ofs);
  endsequence

  sequence s_rd_done(logic [7:0] ofs);
    s_rd(ofs) ##1 !hreadyout ##1 hreadyout;
  endsequence

  sequence s_wr_done(logic [7:0] ofs);
    s_wr(ofs) ##1 hreadyout;
  endsequence

  a_width_write: assert property (s_wr(crc_pkg::OFS_CTRL_ONE) ##1 1'b1
    |=> st.ctrl_one[12:8] == $past(hwdata[12:8]))
    else $error("width field did not take written value");
  a_length_write: assert property (s_wr(crc_pkg::OFS_CTRL_ONE) ##1 1'b1
    |=> cfg.poly_length_minus_one == $past(hwdata[4:0]))
    else $error("length field did not take written value");
  a_ctrl_reserved: assert property ((st.ctrl_one & ~crc_pkg::CTRL_ONE_MASK) == 16'h0000)
    else $error("reserved control bits set");
  a_low_mask_write: assert property (s_wr(crc_pkg::OFS_MASK_LOW) ##1 1'b1
    |=> cfg.poly_mask[15:1] == $past(hwdata[15:1]))
    else $error("low mask not applied to feedback terms");
  a_mask_bit_zero: assert property (!st.mask_low[0] && !cfg.poly_mask[0])
    else $error("constant term mask bit stored");
  a_high_mask_write: assert property (s_wr(crc_pkg::OFS_MASK_HIGH) ##1 1'b1
    |=> cfg.poly_mask[31:16] == $past(hwdata[15:0]))
    else $error("high mask not mapped to powers 16 to 31");
  a_mask_readback: assert property (s_rd(crc_pkg::OFS_MASK_HIGH)
    |=> !hreadyout ##1 (hreadyout && hrdata == {16'h0000, $past(st.mask_high)}))
    else $error("high mask readback wrong");
  a_done_sets_irq: assert property (shift_done && !st.irq_source_select
    |=> st.irq_status[crc_pkg::ST_CRC_BIT])
    else $error("shift complete did not set status");
  a_empty_sets_irq: assert property (st.irq_source_select && fifo_empty && !st.empty_q
    |=> st.irq_status[crc_pkg::ST_CRC_BIT])
    else $error("queue empty did not set status");
  a_empty_flag_read: assert property (s_rd(crc_pkg::OFS_CTRL_TWO)
    |=> ##1 (hreadyout && hrdata[crc_pkg::EMPTY_BIT] == $past(fifo_empty)))
    else $error("empty flag readback wrong");

  // read checks look one edge back: hrdata was built from state then
  a_ctrl_zero_read: assert property (s_rd_done(crc_pkg::OFS_CTRL_ONE)
    |-> (hrdata & ~{16'h0000, crc_pkg::CTRL_ONE_MASK}) == 32'h0000_0000)
    else $error("reserved control bits read nonzero");

  a_width_read: assert property (s_rd_done(crc_pkg::OFS_CTRL_ONE)
    |-> hrdata[crc_pkg::WW_MSB:crc_pkg::WW_LSB] == $past(cfg.word_width_minus_one))
    else $error("width field readback wrong");

  a_length_read: assert property (s_rd_done(crc_pkg::OFS_CTRL_ONE)
    |-> hrdata[crc_pkg::PL_MSB:crc_pkg::PL_LSB] == $past(cfg.poly_length_minus_one))
    else $error("length field readback wrong");

  a_ctrl_write_mask: assert property (s_wr_done(crc_pkg::OFS_CTRL_ONE)
    |=> st.ctrl_one == ($past(hwdata[15:0]) & crc_pkg::CTRL_ONE_MASK))
    else $error("write reached reserved control bits");

  a_low_zero_read: assert property (s_rd_done(crc_pkg::OFS_MASK_LOW)
    |-> hrdata[31:16] == 16'h0000 && !hrdata[0])
    else $error("low mask bit zero read nonzero");

  a_low_mask_read: assert property (s_rd_done(crc_pkg::OFS_MASK_LOW)
    |-> hrdata[15:1] == $past(cfg.poly_mask[15:1]))
    else $error("low mask readback differs from taps");

  a_high_mask_read: assert property (s_rd_done(crc_pkg::OFS_MASK_HIGH)
    |-> hrdata[15:0] == $past(cfg.poly_mask[31:16]))
    else $error("high mask readback differs from taps");

  a_ctrl_held: assert property (!(st.pend_write && st.addr == crc_pkg::OFS_CTRL_ONE)
    |=> $stable(st.ctrl_one))
    else $error("control one changed without a write");

  a_low_held: assert property (!(st.pend_write && st.addr == crc_pkg::OFS_MASK_LOW)
    |=> $stable(st.mask_low))
    else $error("low mask changed without a write");

  a_high_held: assert property (!(st.pend_write && st.addr == crc_pkg::OFS_MASK_HIGH)
    |=> $stable(st.mask_high))
    else $error("high mask changed without a write");

  a_order_write: assert property (s_wr_done(crc_pkg::OFS_CTRL_TWO)
    |=> st.shift_order_select == $past(hwdata[crc_pkg::ORDER_BIT]))
    else $error("order select did not take written value");

  a_order_read: assert property (s_rd_done(crc_pkg::OFS_CTRL_TWO)
    |-> hrdata[crc_pkg::ORDER_BIT] == $past(st.shift_order_select))
    else $error("order select readback wrong");

  a_run_write: assert property (s_wr_done(crc_pkg::OFS_CTRL_TWO)
    |=> st.shifter_run == $past(hwdata[crc_pkg::RUN_BIT]))
    else $error("run bit did not take written value");

  a_run_read: assert property (s_rd_done(crc_pkg::OFS_CTRL_TWO)
    |-> hrdata[crc_pkg::RUN_BIT] == $past(st.shifter_run))
    else $error("run bit readback wrong");

  a_isel_write: assert property (s_wr_done(crc_pkg::OFS_CTRL_TWO)
    |=> st.irq_source_select == $past(hwdata[crc_pkg::ISEL_BIT]))
    else $error("interrupt select did not take written value");

  a_run_off_idle: assert property (!st.shifter_run |=> !shift_busy)
    else $error("shifter busy with run clear");

  a_no_pop_stopped: assert property (!st.shifter_run |-> !word_pop)
    else $error("queue popped with run clear");

  a_pop_starts: assert property (word_pop |=> shift_busy)
    else $error("popped word did not start shifting");

  a_status_read_clear: assert property (s_rd(crc_pkg::OFS_IRQ_STATUS) ##1 1'b1
    |=> st.irq_status[crc_pkg::ST_OVF_BIT] == $past(ovf_event) &&
        st.irq_status[crc_pkg::ST_CRC_BIT] == $past(crc_event))
    else $error("status read did not clear old events");

  a_crc_bit_holds: assert property (!st.irq_source_select && !shift_done && !clear_status
    |=> st.irq_status[crc_pkg::ST_CRC_BIT] == $past(st.irq_status[crc_pkg::ST_CRC_BIT]))
    else $error("crc status bit changed without an event");

  a_irq_level: assert property (irq == |(st.irq_status & st.irq_mask))
    else $error("interrupt line disagrees with masked status");
endmodule

// ### crc_pkg.sv
/*
  constants, offsets, field positions and carrier types of the crc block.
  assumes a 32-bit ahb-lite slave decoding the low eight address bits.
*/
package crc_pkg;
  localparam int        ADDR_W          = 8;
  localparam int        FIFO_DEPTH      = 4;
  localparam int        WORD_W          = 32;

  localparam logic [7:0] OFS_CTRL_ONE   = 8'h00;
  localparam logic [7:0] OFS_MASK_LOW   = 8'h04;
  localparam logic [7:0] OFS_MASK_HIGH  = 8'h08;
  localparam logic [7:0] OFS_CTRL_TWO   = 8'h0c;
  localparam logic [7:0] OFS_DATA_IN    = 8'h10;
  localparam logic [7:0] OFS_RESULT     = 8'h14;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h1c;

  localparam int        WW_LSB          = 8;
  localparam int        WW_MSB          = 12;
  localparam int        PL_LSB          = 0;
  localparam int        PL_MSB          = 4;
  localparam int        ISEL_BIT        = 0;
  localparam int        ORDER_BIT       = 3;
  localparam int        RUN_BIT         = 4;
  localparam int        EMPTY_BIT       = 6;
  localparam int        FULL_BIT        = 7;
  localparam int        ST_CRC_BIT      = 0;
  localparam int        ST_OVF_BIT      = 1;

  localparam logic [15:0] CTRL_ONE_MASK  = 16'h1f1f;
  localparam logic [15:0] MASK_LOW_MASK  = 16'hfffe;
  localparam logic [15:0] MASK_HIGH_MASK = 16'hffff;
  localparam logic [15:0] REG_RESET      = 16'h0000;
  localparam logic [1:0]  IRQ_RESET      = 2'h0;

  typedef struct packed {
    logic [4:0]  word_width_minus_one;
    logic [4:0]  poly_length_minus_one;
    logic [31:0] poly_mask;
    logic        shift_order_select;
  } crc_cfg_s;
endpackage

// ### crc_shifter.sv
/*
  serial crc shifter: one data bit per clock through a masked lfsr.
  assumes configuration is held steady while a word is shifting.
*/
module crc_shifter (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire crc_pkg::crc_cfg_s cfg,
  input  wire logic              run,
  input  wire logic              word_valid,
  input  wire logic [31:0]       word,
  output      logic              word_pop,
  input  wire logic              preload,
  input  wire logic [31:0]       preload_value,
  output      logic [31:0]       crc,
  output      logic              busy,
  output      logic              done
);
  typedef struct packed {
    logic [31:0] crc;
    logic [31:0] word;
    logic [4:0]  idx;
    logic [5:0]  left;
    logic        busy;
  } shift_s;

  shift_s      st;
  shift_s      next_st;
  logic        data_bit;
  logic        fb;
  logic [31:0] stage_next;
  logic        finishing;

  assign data_bit = st.word[st.idx];
  assign fb       = data_bit ^ st.crc[cfg.poly_length_minus_one];
  assign crc      = st.crc;
  assign busy     = st.busy;

  // stage zero is the constant term, always fed back
  assign stage_next[0] = fb;
  for (genvar k = 1; k < 32; k++) begin : g_stage
    assign stage_next[k] = (5'(k) > cfg.poly_length_minus_one) ? 1'b0 :
                           st.crc[k-1] ^ (fb & cfg.poly_mask[k]);
  end

  always_comb begin
    next_st   = st;
    word_pop  = 1'b0;
    done      = 1'b0;
    finishing = st.busy && (st.left == 6'h01);
    if (preload) begin
      next_st.crc = preload_value;
    end else if (st.busy) begin
      next_st.crc  = stage_next;
      next_st.left = st.left - 6'h01;
      next_st.idx  = cfg.shift_order_select ? st.idx + 5'h01 : st.idx - 5'h01;
      if (finishing) begin
        next_st.busy = 1'b0;
        done         = !word_valid;
      end
    end
    // next word starts the cycle after the last bit, no bubble
    if ((!st.busy || finishing) && run && word_valid) begin
      word_pop     = 1'b1;
      next_st.word = word;
      next_st.idx  = cfg.shift_order_select ? 5'h00 : cfg.word_width_minus_one;
      next_st.left = {1'b0, cfg.word_width_minus_one} + 6'h01;
      next_st.busy = 1'b1;
    end
    if (!run) begin
      next_st.busy = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_run_stops_shift: assert property (!run |=> !st.busy)
    else $error("shifter still busy after run cleared");
  a_lsb_first_load: assert property (word_pop && run && cfg.shift_order_select
    |=> st.idx == 5'h00)
    else $error("lsb-first word did not start at bit zero");
  a_msb_first_load: assert property (word_pop && run && !cfg.shift_order_select
    |=> st.idx == $past(cfg.word_width_minus_one))
    else $error("msb-first word did not start at top bit");
  a_feedback_in: assert property (st.busy && run && !preload |=> st.crc[0] == $past(fb))
    else $error("feedback bit not entered at stage zero");
endmodule

// ### tb.sv
/*
  self-checking bench for the crc unit: register reset values and access
  kinds, polynomial and width setup, serial result, queue flags, interrupts.
  assumes crc_pkg and crc_config are compiled first; the bench is the only
  ahb-lite master and feeds hreadyout back as hready.
*/
module tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        irq;
  logic [31:0] got;
  int          mismatches;
  int          checks;

  // one row per crc case: length and width fields, taps, order, word, preload
  logic [4:0]  c_pl [3] = '{5'h0f, 5'h1f, 5'h04};
  logic [4:0]  c_ww [3] = '{5'h07, 5'h1f, 5'h00};
  logic [31:0] c_mk [3] = '{32'h00001021, 32'h04c11db7, 32'h00000015};
  logic        c_ls [3] = '{1'b1, 1'b0, 1'b0};
  logic [31:0] c_dt [3] = '{32'h0000005a, 32'hdeadbeef, 32'h00000001};
  logic [31:0] c_pr [3] = '{32'h0000ffff, 32'hffffffff, 32'h0000001f};

  crc_config dut (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hreadyout),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .irq       (irq)
  );

  always #12.5 hclk = ~hclk;

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // looks at hready mid-cycle so the value used is the one sampled at the edge
  task automatic wait_ready(output logic [31:0] rd);
    int  n;
    bit  ok;
    n = 0;
    ok = 0;
    while (!ok) begin
      @(negedge hclk);
      ok = (hreadyout === 1'b1);
      rd = hrdata;
      @(posedge hclk);
      n++;
      if (n > 50) begin
        mismatches++;
        $display("Error at %0t: bus wait ran out", $time);
        tally_and_finish();
      end
    end
  endtask

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_ready(rd);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwrite <= 1'b0;
    hwdata <= wd;
    wait_ready(rd);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] unused;
    bus(a, 1'b1, d, unused);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(a, 1'b0, 32'h0, r);
    chk(r, e);
  endtask

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1) begin
      @(negedge hclk);
      n++;
      if (n > 100) begin
        mismatches++;
        $display("Error at %0t: interrupt never came", $time);
        tally_and_finish();
      end
    end
  endtask

  // independent bit-serial reference; bit 0 of the taps is never stored
  function automatic logic [31:0] crc_ref(input logic [31:0] c, input logic [31:0] d,
                                          input logic [31:0] mk, input int w,
                                          input int l, input logic lsb);
    logic [31:0] nc;
    logic        fb;
    for (int i = 0; i < w; i++) begin
      fb = d[lsb ? i : w - 1 - i] ^ c[l - 1];
      nc = 32'h0;
      nc[0] = fb;
      for (int k = 1; k < l; k++) begin
        nc[k] = c[k - 1] ^ (fb & mk[k]);
      end
      c = nc;
    end
    return c;
  endfunction

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    mismatches = 0;
    checks = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(crc_pkg::OFS_CTRL_ONE, 32'h0);
    rd_chk(crc_pkg::OFS_MASK_LOW, 32'h0);
    rd_chk(crc_pkg::OFS_MASK_HIGH, 32'h0);
    rd_chk(crc_pkg::OFS_CTRL_TWO, 32'h40);
    rd_chk(crc_pkg::OFS_IRQ_STATUS, 32'h0);
    rd_chk(crc_pkg::OFS_RESULT, 32'h0);
    @(negedge hclk);
    chk({31'h0, irq}, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    wr(crc_pkg::OFS_CTRL_ONE, 32'hffffffff);
    rd_chk(crc_pkg::OFS_CTRL_ONE, 32'h1f1f);
    wr(crc_pkg::OFS_MASK_LOW, 32'hffffffff);
    rd_chk(crc_pkg::OFS_MASK_LOW, 32'hfffe);
    wr(crc_pkg::OFS_MASK_HIGH, 32'hffffffff);
    rd_chk(crc_pkg::OFS_MASK_HIGH, 32'hffff);
    wr(8'h20, 32'hffffffff);
    rd_chk(8'h20, 32'h0);
    for (int i = 0; i < 3; i++) begin
      wr(crc_pkg::OFS_CTRL_TWO, {27'h0, 1'b1, c_ls[i], 3'h0});
      wr(crc_pkg::OFS_CTRL_ONE, {19'h0, c_ww[i], 3'h0, c_pl[i]});
      wr(crc_pkg::OFS_MASK_LOW, {16'h0, c_mk[i][15:0]});
      wr(crc_pkg::OFS_MASK_HIGH, {16'h0, c_mk[i][31:16]});
      rd_chk(crc_pkg::OFS_MASK_LOW, {16'h0, c_mk[i][15:1], 1'b0});
      wr(crc_pkg::OFS_RESULT, c_pr[i]);
      wr(crc_pkg::OFS_IRQ_MASK, 32'h1);
      bus(crc_pkg::OFS_IRQ_STATUS, 1'b0, 32'h0, got);
      wr(crc_pkg::OFS_DATA_IN, c_dt[i]);
      wait_irq();
      rd_chk(crc_pkg::OFS_RESULT, crc_ref(c_pr[i], c_dt[i], c_mk[i],
             c_ww[i] + 1, c_pl[i] + 1, c_ls[i]));
      wr(crc_pkg::OFS_IRQ_MASK, 32'h0);
      repeat (2) @(negedge hclk);
      chk({31'h0, irq}, 32'h0);
      rd_chk(crc_pkg::OFS_IRQ_STATUS, 32'h1);
      rd_chk(crc_pkg::OFS_IRQ_STATUS, 32'h0);
    end
    // shifter off: a queued word must wait and leave the result alone
    wr(crc_pkg::OFS_CTRL_TWO, 32'h0);
    wr(crc_pkg::OFS_RESULT, 32'h0000000a);
    wr(crc_pkg::OFS_DATA_IN, 32'h1);
    rd_chk(crc_pkg::OFS_CTRL_TWO, 32'h0);
    repeat (10) @(posedge hclk);
    rd_chk(crc_pkg::OFS_RESULT, 32'h0000000a);
    wr(crc_pkg::OFS_IRQ_MASK, 32'h1);
    wr(crc_pkg::OFS_CTRL_TWO, 32'h11);
    wait_irq();
    repeat (4) @(posedge hclk);
    rd_chk(crc_pkg::OFS_RESULT, crc_ref(32'ha, 32'h1, c_mk[2], 1, 5, 1'b0));
    rd_chk(crc_pkg::OFS_CTRL_TWO, 32'h51);
    rd_chk(crc_pkg::OFS_IRQ_STATUS, 32'h1);
    // overflow: fifth word into a four-deep queue is dropped and flagged
    wr(crc_pkg::OFS_CTRL_TWO, 32'h0);
    wr(crc_pkg::OFS_IRQ_MASK, 32'h2);
    for (int k = 0; k < 5; k++) begin
      wr(crc_pkg::OFS_DATA_IN, k);
    end
    rd_chk(crc_pkg::OFS_CTRL_TWO, 32'h80);
    @(negedge hclk);
    chk({31'h0, irq}, 32'h1);
    rd_chk(crc_pkg::OFS_IRQ_STATUS, 32'h2);
    repeat (2) @(negedge hclk);
    chk({31'h0, irq}, 32'h0);
    wr(crc_pkg::OFS_CTRL_TWO, 32'h10);
    repeat (20) @(posedge hclk);
    rd_chk(crc_pkg::OFS_CTRL_TWO, 32'h50);
    // reset with run set clears control one, low mask and status and stops the shifter
    wr(crc_pkg::OFS_MASK_LOW, 32'h0000fffe);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(crc_pkg::OFS_CTRL_ONE, 32'h0);
    rd_chk(crc_pkg::OFS_MASK_LOW, 32'h0);
    rd_chk(crc_pkg::OFS_CTRL_TWO, 32'h40);
    rd_chk(crc_pkg::OFS_IRQ_STATUS, 32'h0);
    tally_and_finish();
  end
endmodule

// ### word_queue.sv
/*
  small input word queue feeding the crc shifter.
  assumes one clock; push and pop are single-cycle handshakes.
*/
module word_queue #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output      logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output      logic             out_valid,
  input  wire logic             out_ready,
  output      logic [WIDTH-1:0] out_data,
  output      logic             empty
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(DEPTH);
  localparam logic [PTR_W-1:0] LAST_PTR   = PTR_W'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0]            wr;
    logic [PTR_W-1:0]            rd;
    logic [CNT_W-1:0]            count;
  } queue_s;

  queue_s st;
  queue_s next_st;
  logic   do_push;
  logic   do_pop;

  assign in_ready  = (st.count != FULL_COUNT);
  assign out_valid = (st.count != '0);
  assign empty     = (st.count == '0);
  assign out_data  = st.mem[st.rd];

  always_comb begin
    next_st = st;
    do_push = in_valid && in_ready;
    do_pop  = out_valid && out_ready;
    if (do_push) begin
      next_st.mem[st.wr] = in_data;
      next_st.wr         = (st.wr == LAST_PTR) ? '0 : st.wr + 1'b1;
    end
    if (do_pop) begin
      next_st.rd = (st.rd == LAST_PTR) ? '0 : st.rd + 1'b1;
    end
    if (do_push && !do_pop) begin
      next_st.count = st.count + 1'b1;
    end else if (do_pop && !do_push) begin
      next_st.count = st.count - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule
